// *** mfs_sequencer.sv ***
`timescale 1ns/1ps
// How it works
// - microword fields at fixed 32-bit positions
// - function or store code picks format
// - rank1 holds I, address I+1, rank2 I-1
// - source fields come straight from rank1
// - function then shift act from rank2
// - met skip NOPs rank1 one cycle
// - store executes with address I+3 loaded
// - jump uses bits 20-31 as target
// - jump or call only when condition holds
// - data-dependent jump freezes one cycle first
// - constant word loads bits 16-31 into B
// - constant variants give fixed alu codes
// - constant result stored by store field
// - repeat loads count from skip field
// - increment and counter-maximum drive the repeat
// - bus stores turn special into memory option
// - low and pointer stores start memory
// - high bus store drives central data bus
module mfs_sequencer (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [3:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire mfs_pkg::mfs_word_t       rom_data_i,
  input  wire logic                     skip_met_i,
  output logic [mfs_pkg::ADDR_W-1:0]    rom_addr_o,
  output logic [4:0]                    src_a_o,
  output logic [3:0]                    src_b_o,
  output logic                          const_load_o,
  output logic [15:0]                   constant_o,
  output logic [4:0]                    function_o,
  output logic [3:0]                    alu_select_code_o,
  output logic [2:0]                    shift_o,
  output logic [4:0]                    skip_code_o,
  output mfs_pkg::mfs_exec_t            exec_o,
  output logic [mfs_pkg::ADDR_W-1:0]    save_addr_o
);
  mfs_pkg::mfs_word_t         rank1, rank2;          // output_rank_first / second
  mfs_pkg::mfs_exec_t         exec_stage;
  logic [mfs_pkg::ADDR_W-1:0] microaddress_register, save_addr;        // microaddress_register
  logic [4:0]                 rep_ctr;
  logic                       repeating, frozen, run, ack;

  // rank1 decode: constant words drop the B field and carry a constant
  wire r1_const = rank1.func == mfs_pkg::FN_CONST || rank1.func == mfs_pkg::FN_CONST_OR ||
                  rank1.func == mfs_pkg::FN_CONST_AND || rank1.func == mfs_pkg::FN_CONST_XOR;

  // rank2 format decode
  wire r2_jump  = rank2.func == mfs_pkg::FN_JUMP || rank2.func == mfs_pkg::FN_SUB_JUMP;
  wire r2_call  = rank2.func == mfs_pkg::FN_SUB_JUMP;
  wire r2_const = rank2.func == mfs_pkg::FN_CONST || rank2.func == mfs_pkg::FN_CONST_OR ||
                  rank2.func == mfs_pkg::FN_CONST_AND || rank2.func == mfs_pkg::FN_CONST_XOR;
  wire r2_rep   = rank2.func == mfs_pkg::FN_REPEAT;
  wire r2_bus   = rank2.store == mfs_pkg::ST_LOW_BUS || rank2.store == mfs_pkg::ST_POINTER_BUS ||
                  rank2.store == mfs_pkg::ST_HIGH_BUS;
  wire r2_plain = !r2_jump && !r2_const && !r2_rep;  // operate or memory option format
  wire ctr_max  = rep_ctr == mfs_pkg::CTR_MAX;
  wire [mfs_pkg::ADDR_W-1:0] target = rank2[11:0];   // bits 20-31

  // skip condition: counter, unconditional and no-op codes are local, the rest come from the datapath
  wire cond_met = (rank2.skip == mfs_pkg::SK_CTR_MAX) ? ctr_max :
                  (rank2.skip == mfs_pkg::SK_UNCOND)  ? 1'b1 :
                  (rank2.skip == mfs_pkg::FIELD_NOP)  ? 1'b0 : skip_met_i;
  wire data_dep = rank2.skip < mfs_pkg::SK_DATA_LIMIT;

  // freeze gives the result bus one cycle to settle before a data
  wire need_freeze = run && r2_jump && data_dep && !frozen;
  wire hold        = !run || need_freeze;
  wire take_jump   = !hold && r2_jump && cond_met;
  wire take_skip   = !hold && r2_plain && !repeating && cond_met;
  wire rep_end     = repeating && rank2.skip == mfs_pkg::SK_CTR_MAX && ctr_max;
  wire rep_hold    = r2_rep || (repeating && !rep_end);
  wire inc_ctr     = !hold && r2_plain && !r2_bus && rank2.special == mfs_pkg::SP_INC_CTR;

  // register bus decode; writes take effect on the acking edge
  wire wb_req    = wb_cyc_i && wb_stb_i;
  wire wr_en     = wb_req && wb_we_i && ack;
  wire wr_ctrl   = wr_en && wb_adr_i == mfs_pkg::REG_CTRL && wb_sel_i[0];
  wire wr_start  = wr_en && wb_adr_i == mfs_pkg::REG_START && wb_sel_i[0] && wb_sel_i[1];
  wire [31:0] status = {12'h000, frozen, repeating, 1'b0, rep_ctr, microaddress_register};
  wire [31:0] rd_mux = (wb_adr_i == mfs_pkg::REG_CTRL)   ? {31'h0000_0000, run} :
                       (wb_adr_i == mfs_pkg::REG_STATUS) ? status :
                       (wb_adr_i == mfs_pkg::REG_SAVE)   ? {20'h0_0000, save_addr} : 32'h0000_0000;

  // pipeline advance: address runs two words ahead of execution
  wire [mfs_pkg::ADDR_W-1:0] next_rar =
    wr_start  ? wb_dat_i[mfs_pkg::ADDR_W-1:0] :
    hold      ? microaddress_register :
    take_jump ? target :
    rep_hold  ? microaddress_register : mfs_pkg::ADDR_W'(microaddress_register + 1'b1);
  wire mfs_pkg::mfs_word_t next_rank1 =
    wr_start  ? mfs_pkg::NOP_WORD :
    hold      ? rank1 :
    take_jump ? mfs_pkg::NOP_WORD :
    rep_hold  ? rank1 : rom_data_i;                                 // repeated word stays
  // rank1 still holds a copy of the repeated word when a repeat ends; a bubble keeps it from running once more
  wire mfs_pkg::mfs_word_t next_rank2 =
    wr_start  ? mfs_pkg::NOP_WORD :
    hold      ? rank2 :
    (take_jump || take_skip || rep_end) ? mfs_pkg::NOP_WORD : rank1;

  // store and special decode of the word leaving rank2
  mfs_pkg::mfs_exec_t next_exec;
  always_comb begin
    next_exec = {mfs_pkg::FIELD_NOP, mfs_pkg::FIELD_NOP, mfs_pkg::FIELD_NOP, 1'b0, 1'b0};
    if (!hold && !wr_start) begin
      next_exec.store = rank2.store;
      if (r2_bus) begin
        next_exec.mcu_option     = rank2.special;
        next_exec.mem_start      = rank2.store != mfs_pkg::ST_HIGH_BUS;
        next_exec.high_bus_store = rank2.store == mfs_pkg::ST_HIGH_BUS;
      end else if (r2_plain) begin
        next_exec.special = rank2.special;
      end
    end
  end

  // sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      microaddress_register   <= '0;
      rank1 <= mfs_pkg::NOP_WORD;
      rank2 <= mfs_pkg::NOP_WORD;
      exec_stage <= {mfs_pkg::FIELD_NOP, mfs_pkg::FIELD_NOP, mfs_pkg::FIELD_NOP, 1'b0, 1'b0};
    end else begin
      microaddress_register   <= next_rar;
      rank1 <= next_rank1;
      rank2 <= next_rank2;
      exec_stage <= next_exec;
    end
  end

  // repeat counter, freeze flag and return address
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_start) begin
      rep_ctr   <= '0;
      repeating <= 1'b0;
      frozen    <= 1'b0;
    end else begin
      frozen <= need_freeze;
      if (!hold && r2_rep) begin
        rep_ctr   <= rank2.skip;
        repeating <= 1'b1;
      end else begin
        if (inc_ctr) rep_ctr <= rep_ctr + 1'b1;
        if (!hold && rep_end) repeating <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) save_addr <= '0;
    else if (take_jump && r2_call) save_addr <= mfs_pkg::ADDR_W'(microaddress_register - 1'b1);
  end

  // wishbone slave: one wait state, ack dropped the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run      <= mfs_pkg::CTRL_RESET;
    end else begin
      ack      <= wb_req && !ack;
      wb_dat_o <= rd_mux;
      if (wr_ctrl) run <= wb_dat_i[0];
    end
  end

  // outputs toward rom and datapath
  assign wb_ack_o     = ack;
  assign rom_addr_o   = microaddress_register;
  assign src_a_o      = rank1.src_a;
  assign src_b_o      = r1_const ? mfs_pkg::SRC_B_NOP : rank1.src_b;
  assign const_load_o = r1_const;
  assign constant_o   = rank1[15:0];
  assign function_o   = rank2.func;
  assign alu_select_code_o =
    (rank2.func == mfs_pkg::FN_CONST)     ? mfs_pkg::ALU_ADD :
    (rank2.func == mfs_pkg::FN_CONST_OR)  ? mfs_pkg::ALU_OR :
    (rank2.func == mfs_pkg::FN_CONST_AND) ? mfs_pkg::ALU_AND :
    (rank2.func == mfs_pkg::FN_CONST_XOR) ? mfs_pkg::ALU_XOR : 4'h0;
  assign shift_o      = (r2_jump || r2_const) ? mfs_pkg::SHIFT_NOP : rank2.shift;
  assign skip_code_o  = rank2.skip;
  assign exec_o       = exec_stage;
  assign save_addr_o  = save_addr;

  // checks
  rank_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && !need_freeze && !take_jump && !rep_hold && !wr_start) |=> microaddress_register == $past(microaddress_register) + 12'h001)
    else $error("address did not advance");
  store_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_plain && !r2_bus) |=> exec_o.store == $past(rank2.store))
    else $error("store not one stage behind rank2");
  skip_nop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_skip && !wr_start) |=> rank2 == mfs_pkg::NOP_WORD)
    else $error("skip did not squash next word");
  jump_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_jump && !wr_start) |=> microaddress_register == $past(rank2[11:0]) && rank1 == mfs_pkg::NOP_WORD)
    else $error("jump target not loaded");
  jump_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && !wr_start && r2_jump && !data_dep && !cond_met) |=> microaddress_register == $past(microaddress_register) + 12'h001)
    else $error("jump taken without condition");
  freeze_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (need_freeze && !wr_start) |=> frozen && microaddress_register == $past(microaddress_register) ##1 !frozen)
    else $error("freeze not exactly one cycle");
  const_alu_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rank2.func == mfs_pkg::FN_CONST_AND) |-> alu_select_code_o == 4'hD && shift_o == 3'h7)
    else $error("constant alu code wrong");
  const_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r1_const |-> src_b_o == 4'hF && const_load_o && constant_o == rank1[15:0])
    else $error("constant not routed");
  repeat_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && r2_rep && !wr_start) |=> repeating && rep_ctr == $past(rank2.skip) && microaddress_register == $past(microaddress_register))
    else $error("repeat count not loaded");
  bus_option_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_plain && r2_bus) |=> exec_o.special == 5'h1F
      && exec_o.mcu_option == $past(rank2.special) && (exec_o.mem_start != exec_o.high_bus_store))
    else $error("memory option not routed");

  // pipeline movement
  rank_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && !take_jump && !rep_hold) |=> rank1 == $past(rom_data_i))
    else $error("rank1 not loaded from rom");
  rank_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && !take_jump && !take_skip && !rep_end) |=> rank2 == $past(rank1))
    else $error("rank2 did not follow rank1");
  hold_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (hold && !wr_start) |=> microaddress_register == $past(microaddress_register) && rank1 == $past(rank1) && rank2 == $past(rank2))
    else $error("pipeline moved while held");
  data_test_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (need_freeze && !wr_start) |=> frozen && rank2 == $past(rank2) && exec_o.store == mfs_pkg::FIELD_NOP)
    else $error("data jump not frozen");

  // field routing
  src_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !r1_const |-> src_b_o == rank1.src_b && src_a_o == rank1.src_a)
    else $error("source fields not from rank1");
  shift_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!r2_jump && !r2_const) |-> shift_o == rank2.shift && function_o == rank2.func)
    else $error("shift or function not from rank2");
  jump_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r2_jump |-> shift_o == mfs_pkg::SHIFT_NOP && alu_select_code_o == 4'h0)
    else $error("jump target bits decoded as fields");
  const_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r2_const |-> shift_o == mfs_pkg::SHIFT_NOP)
    else $error("constant bits decoded as shift");
  const_special_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_const) |=> exec_o.special == mfs_pkg::FIELD_NOP)
    else $error("constant bits decoded as special");
  const_add_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rank2.func == mfs_pkg::FN_CONST) |-> alu_select_code_o == 4'h9)
    else $error("constant add code wrong");
  const_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rank2.func == mfs_pkg::FN_CONST_OR) |-> alu_select_code_o == 4'h8)
    else $error("constant or code wrong");
  const_xor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rank2.func == mfs_pkg::FN_CONST_XOR) |-> alu_select_code_o == 4'h6)
    else $error("constant xor code wrong");
  operate_special_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_plain && !r2_bus) |=> exec_o.special == $past(rank2.special) && !exec_o.mem_start)
    else $error("operate word special not passed");

  // jumps and calls
  uncond_jump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_jump && rank2.skip == mfs_pkg::SK_UNCOND) |=> microaddress_register == $past(rank2[11:0]))
    else $error("unconditional jump not taken");
  call_save_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_jump && r2_call) |=> save_addr_o == $past(microaddress_register) - 12'h001)
    else $error("return address not saved");
  jump_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_jump && !r2_call) |=> save_addr_o == $past(save_addr_o))
    else $error("plain jump changed return address");

  // repeat
  repeat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && repeating && !rep_end && !take_jump) |=> microaddress_register == $past(microaddress_register) && rank1 == $past(rank1))
    else $error("repeated word not held");
  counter_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (inc_ctr && !wr_start) |=> rep_ctr == $past(rep_ctr) + 5'h01)
    else $error("repeat counter did not step");
  repeat_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && rep_end && !r2_rep) |=> !repeating && rank2 == mfs_pkg::NOP_WORD)
    else $error("repeat did not end cleanly");

  // execution stage
  exec_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (hold || wr_start) |=> exec_o.store == mfs_pkg::FIELD_NOP && !exec_o.mem_start && !exec_o.high_bus_store)
    else $error("store executed while held");
  mem_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && r2_bus && rank2.store != mfs_pkg::ST_HIGH_BUS) |=> exec_o.mem_start)
    else $error("memory operation not started");
  high_bus_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hold && !wr_start && rank2.store == mfs_pkg::ST_HIGH_BUS) |=> exec_o.high_bus_store && !exec_o.mem_start)
    else $error("high bus store not driven");
endmodule : mfs_sequencer

// *** mfs_pkg.sv ***
package mfs_pkg;
  // microword fields, leftmost field in the most significant bits
  typedef struct packed {
    logic [4:0] src_a;
    logic [4:0] store;
    logic [4:0] func;
    logic [4:0] skip;
    logic [2:0] shift;
    logic [4:0] special;
    logic [3:0] src_b;
  } mfs_word_t;

  // store and special actions driven toward the datapath and memory control
  typedef struct packed {
    logic [4:0] store;
    logic [4:0] special;
    logic [4:0] mcu_option;
    logic       mem_start;
    logic       high_bus_store;
  } mfs_exec_t;

  localparam int        ADDR_W          = 12;
  localparam mfs_word_t NOP_WORD        = 32'hFFFF_FFFF;
  localparam logic [4:0] FIELD_NOP      = 5'h1F;
  localparam logic [3:0] SRC_B_NOP      = 4'hF;
  localparam logic [2:0] SHIFT_NOP      = 3'h7;
  // function codes
  localparam logic [4:0] FN_SUB_JUMP    = 5'h04;
  localparam logic [4:0] FN_JUMP        = 5'h0C;
  localparam logic [4:0] FN_CONST_XOR   = 5'h02;
  localparam logic [4:0] FN_CONST_AND   = 5'h03;
  localparam logic [4:0] FN_CONST_OR    = 5'h12;
  localparam logic [4:0] FN_CONST       = 5'h13;
  localparam logic [4:0] FN_REPEAT      = 5'h15;
  // store codes that select the memory option format
  localparam logic [4:0] ST_LOW_BUS     = 5'h04;
  localparam logic [4:0] ST_POINTER_BUS = 5'h05;
  localparam logic [4:0] ST_HIGH_BUS    = 5'h06;
  // skip codes; codes below the limit test result bus data
  localparam logic [4:0] SK_DATA_LIMIT  = 5'h0C;
  localparam logic [4:0] SK_CTR_MAX     = 5'h1B;
  localparam logic [4:0] SK_UNCOND      = 5'h1E;
  localparam logic [4:0] SP_INC_CTR     = 5'h0B;
  localparam logic [4:0] CTR_MAX        = 5'h1F;
  // alu select codes for the constant variants
  localparam logic [3:0] ALU_ADD        = 4'h9;
  localparam logic [3:0] ALU_OR         = 4'h8;
  localparam logic [3:0] ALU_AND        = 4'hD;
  localparam logic [3:0] ALU_XOR        = 4'h6;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_START      = 4'h4;
  localparam logic [3:0] REG_STATUS     = 4'h8;
  localparam logic [3:0] REG_SAVE       = 4'hC;
  localparam logic       CTRL_RESET     = 1'b0;
endpackage : mfs_pkg

// *** mfs_far_model.sv ***
`timescale 1ns/1ps
// far side: microprogram rom, datapath skip evaluation and memory control
module mfs_far_model (
  input  wire logic                       clk_i,
  input  wire logic [mfs_pkg::ADDR_W-1:0] rom_addr_i,
  input  wire logic [4:0]                 skip_code_i,
  input  wire logic                       cond_i,
  input  wire mfs_pkg::mfs_exec_t         exec_i,
  output mfs_pkg::mfs_word_t              rom_data_o,
  output logic                            skip_met_o
);
  mfs_pkg::mfs_word_t rom [0:63];
  int                 mem_ops;
  // unprogrammed space reads as no-op words so a runaway sequencer stays harmless
  assign rom_data_o = (rom_addr_i < 12'h040) ? rom[rom_addr_i[5:0]] : mfs_pkg::NOP_WORD;
  // only result-bus codes are judged here; the sequencer settles the local ones
  assign skip_met_o = cond_i && (skip_code_i < mfs_pkg::SK_DATA_LIMIT);
  // one memory operation per start strobe, with the option code beside it
  always @(posedge clk_i) begin
    if (exec_i.mem_start === 1'b1) begin
      mem_ops <= mem_ops + 1;
    end
  end
  initial begin
    mem_ops = 0;
    for (int i = 0; i < 64; i++) begin
      rom[i] = mfs_pkg::NOP_WORD;
    end
  end
endmodule : mfs_far_model

// *** mfs_sequencer_bench.sv ***
`timescale 1ns/1ps
module mfs_sequencer_bench;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, skip_met, const_load;
  logic [3:0] wb_adr, wb_sel, src_b, alu_sel;
  logic [31:0] wb_wd, wb_rd, rd;
  logic [11:0] rom_addr, save_addr;
  logic [15:0] konst;
  logic [4:0] src_a, func, skip_code;
  logic [2:0] shift;
  mfs_pkg::mfs_word_t rom_data;
  mfs_pkg::mfs_exec_t exec;
  int errors, check_count, cycles, n_call, n_inc, n_st9, n_hb, n_lost, n_sh;
  logic [4:0] cfn [4];
  logic [3:0] calu [4];

  mfs_sequencer u_mfs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .rom_data_i(rom_data), .skip_met_i(skip_met), .rom_addr_o(rom_addr),
    .src_a_o(src_a), .src_b_o(src_b), .const_load_o(const_load), .constant_o(konst), .function_o(func),
    .alu_select_code_o(alu_sel), .shift_o(shift), .skip_code_o(skip_code), .exec_o(exec),
    .save_addr_o(save_addr));
  mfs_far_model u_mfs_far_model (.clk_i(clk_i), .rom_addr_i(rom_addr), .skip_code_i(skip_code),
    .cond_i(1'b1), .exec_i(exec), .rom_data_o(rom_data), .skip_met_o(skip_met));

  always #2.5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // one classic cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= 4'hF;
    wb_adr <= adr;
    wb_wd  <= wd;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rdv = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  // hang guard, well above the few dozen cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  // pipeline watch, sampled mid-cycle when outputs are settled
  always @(negedge clk_i) begin
    if (!rst_i) begin
      if (src_a === 5'h01) chk(32'(rom_addr), 32'h0000_0011, "rank1 addr");
      if (exec.store === 5'h08) chk(32'(rom_addr), 32'h0000_0013, "store addr");
      if (src_a === 5'h02) chk({const_load, src_b, konst}, {1'b1, 4'hF, 16'hABCD}, "const");
      for (int i = 0; i < 4; i++) begin
        if (func === cfn[i]) chk({alu_sel, 1'b0, shift}, {calu[i], 1'b0, 3'h7}, "alu code");
      end
      if (exec.mem_start === 1'b1) chk(32'(exec.mcu_option), 32'h0000_000A, "option");
      n_call += int'(func === mfs_pkg::FN_SUB_JUMP);
      n_inc  += int'(exec.special === mfs_pkg::SP_INC_CTR);
      n_st9  += int'(exec.store === 5'h09);
      n_hb   += int'(exec.high_bus_store === 1'b1);
      n_lost += int'(exec.store === 5'h0D || exec.store === 5'h0E);
      n_sh   += int'(func === 5'h07 && shift === 3'h0);
    end
  end

  initial begin
    {clk_i, wb_cyc, wb_stb, wb_we} = '0;
    {errors, check_count, cycles, n_call, n_inc, n_st9, n_hb, n_lost, n_sh} = '0;
    rst_i = 1'b1;
    wb_adr = 4'h0;
    wb_sel = 4'hF;
    wb_wd = '0;
    cfn = '{mfs_pkg::FN_CONST, mfs_pkg::FN_CONST_OR, mfs_pkg::FN_CONST_AND, mfs_pkg::FN_CONST_XOR};
    calu = '{4'h9, 4'h8, 4'hD, 4'h6};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // microprogram: operate, four constants, memory, jump, call, repeat, skip
    u_mfs_far_model.rom[16] = {5'h01, 5'h08, 5'h07, 5'h1F, 3'h0, 5'h10, 4'h0};
    for (int i = 0; i < 4; i++) u_mfs_far_model.rom[17+i] = {5'h02, 5'h09, cfn[i], 1'b0, 16'hABCD};
    u_mfs_far_model.rom[21] = {5'h1F, mfs_pkg::ST_LOW_BUS, 5'h07, 5'h1F, 3'h7, 5'h0A, 4'hF};
    u_mfs_far_model.rom[22] = {5'h1F, 5'h1F, mfs_pkg::FN_JUMP, mfs_pkg::SK_UNCOND, 12'h020};
    u_mfs_far_model.rom[23] = {5'h1F, 5'h0D, 5'h07, 5'h1F, 3'h7, 5'h1F, 4'hF};
    u_mfs_far_model.rom[32] = {5'h04, 5'h1F, mfs_pkg::FN_SUB_JUMP, 5'h00, 12'h030};
    u_mfs_far_model.rom[48] = {5'h1F, 5'h1F, mfs_pkg::FN_REPEAT, 5'h1E, 3'h7, 5'h1F, 4'hF};
    u_mfs_far_model.rom[49] = {5'h07, 5'h1F, 5'h07, mfs_pkg::SK_CTR_MAX, 3'h7, mfs_pkg::SP_INC_CTR, 4'hF};
    u_mfs_far_model.rom[50] = {5'h1F, 5'h1F, 5'h07, 5'h01, 3'h7, 5'h1F, 4'hF};
    u_mfs_far_model.rom[51] = {5'h1F, 5'h0E, 5'h07, 5'h1F, 3'h7, 5'h1F, 4'hF};
    u_mfs_far_model.rom[52] = {5'h1F, mfs_pkg::ST_HIGH_BUS, 5'h07, 5'h1F, 3'h7, 5'h1F, 4'hF};
    // jump that never meets its condition; taking it would rerun the program and break every count but n_lost
    u_mfs_far_model.rom[53] = {5'h1F, 5'h1F, mfs_pkg::FN_JUMP, mfs_pkg::FIELD_NOP, 12'h010};
    wb_xfer(1'b0, mfs_pkg::REG_STATUS, '0, rd);
    chk(rd, 32'h0000_0000, "status after reset");
    wb_xfer(1'b0, 4'h2, '0, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    $display("test registers done");
    wb_xfer(1'b1, mfs_pkg::REG_START, 32'h0000_0010, rd);
    wb_xfer(1'b1, mfs_pkg::REG_CTRL, 32'h0000_0001, rd);
    for (int n = 0; n < 400 && rom_addr < 12'h038; n++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk(32'(n_call), 32'h0000_0002, "call held for freeze");
    chk(32'(n_st9), 32'h0000_0004, "constant stores");
    chk(32'(n_inc), 32'h0000_0002, "repeat passes");
    chk(32'(n_lost), 32'h0000_0000, "squashed or jumped-over words");
    chk(32'(n_hb), 32'h0000_0001, "high bus store");
    chk(32'(n_sh), 32'h0000_0001, "operate shift passed");
    chk(32'(u_mfs_far_model.mem_ops), 32'h0000_0001, "memory starts");
    chk(32'(save_addr), 32'h0000_0021, "return address");
    wb_xfer(1'b0, mfs_pkg::REG_SAVE, '0, rd);
    chk(rd, 32'h0000_0021, "save register");
    $display("test program done");
    end_of_test();
  end
endmodule : mfs_sequencer_bench
